// [rtl/hpm_master.sv]
`timescale 1ns/100ps
`default_nettype none
module hpm_master import hpm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [3:0] i_req_addr,
  input wire logic [31:0] i_req_wdata,
  input wire logic [3:0] i_req_be_n,
  input wire logic i_dsp0_ready_line_n,
  input wire logic [15:0] i_muxed_port_bus,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_rdata,
  output logic o_seq_error,
  output logic o_access_select_low,
  output logic o_access_select_high,
  output logic o_port_read_not_write,
  output logic o_dsp0_chip_select_n,
  output logic o_port_data_strobe_n,
  output logic o_halfword_position_select,
  output logic o_low_byte_enable_n,
  output logic o_high_byte_enable_n,
  output logic [15:0] o_muxed_port_bus,
  output logic o_muxed_port_bus_oe
);
  hpm_state_t state_q, state_d;
  logic rdy_s1_q, rdy_s2_q;
  logic [15:0] rd_s1_q, rd_s2_q;
  logic ctrl_done_q, addr_done_q;
  logic [1:0] sel_q;
  logic wr_q, cs_n_q, stb_n_q, hsel_q, oe_q, ack_q, rsp_q, err_q;
  logic [15:0] bus_q;
  logic [1:0] be_q;
  logic [31:0] word_q, rdata_q;
  logic [3:0] wbe_q;
  logic [1:0] blank_q;
  logic rnw_q;

  // Ready pin and read bus are asynchronous: two flops before use
  always_ff @(posedge i_clk) begin
    rdy_s1_q <= i_dsp0_ready_line_n;
    rdy_s2_q <= rdy_s1_q;
    rd_s1_q <= i_muxed_port_bus;
    rd_s2_q <= rd_s1_q;
  end

  // Address decode of the host request
  // select from address
  wire [1:0] req_sel = i_req_addr[1:0];
  wire req_is_data = req_sel[1];
  wire order_ok = req_is_data ? (ctrl_done_q && addr_done_q) :
                  (req_sel == HPM_SEL_CTRL) ? 1'b1 : ctrl_done_q;
  wire take = (state_q == HPM_IDLE) && i_req_valid;
  // synced ready pin, low is ready
  // blank stale ready
  // Synced pin lags three edges, so the level left from the previous
  // strobe must not end the new one early
  wire dsp_ready = !rdy_s2_q && (blank_q == 2'h0);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      HPM_IDLE: if (take && order_ok) state_d = HPM_SETUP;
      HPM_SETUP: state_d = HPM_STB1;
      HPM_STB1: if (dsp_ready) state_d = HPM_GAP;
      HPM_GAP: state_d = HPM_STB2;
      HPM_STB2: if (dsp_ready) state_d = HPM_DONE;
      HPM_DONE: state_d = HPM_IDLE;
      default: state_d = HPM_IDLE;
    endcase
  end

  // low half first; byte enables per half
  wire [15:0] half_lo = word_q[15:0];
  wire [15:0] half_hi = word_q[31:16];
  wire [1:0] be_lo = wr_q && sel_q[1] ? wbe_q[1:0] : 2'h0;
  wire [1:0] be_hi = wr_q && sel_q[1] ? wbe_q[3:2] : 2'h0;

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= HPM_IDLE;
      ctrl_done_q <= 1'b0;
      addr_done_q <= 1'b0;
      sel_q <= HPM_SEL_CTRL;
      wr_q <= 1'b0;
      cs_n_q <= 1'b1;
      stb_n_q <= 1'b1;
      hsel_q <= 1'b0;
      oe_q <= 1'b0;
      bus_q <= HPM_BUS_RST;
      be_q <= HPM_BE_RST;
      word_q <= HPM_WORD_RST;
      wbe_q <= 4'hf;
      rdata_q <= HPM_WORD_RST;
      ack_q <= 1'b0;
      rsp_q <= 1'b0;
      err_q <= 1'b0;
      blank_q <= 2'h0;
      rnw_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ack_q <= take;
      rsp_q <= (state_q == HPM_DONE);
      // Refused out-of-order access answered with error pulse
      err_q <= take && !order_ok;
      // Blanking count runs down to zero after each strobe
      blank_q <= (blank_q == 2'h0) ? 2'h0 : blank_q - 2'h1;
      case (state_q)
        HPM_IDLE: if (take && order_ok) begin
          sel_q <= req_sel;
          wr_q <= i_req_write;
          rnw_q <= !i_req_write;
          // force reserved control bits to zero
          word_q <= (req_sel == HPM_SEL_CTRL) ?
            (i_req_wdata & 32'h001f_001f) : i_req_wdata;
          wbe_q <= i_req_be_n;
          hsel_q <= 1'b0;
        end
        HPM_SETUP: begin
          cs_n_q <= 1'b0;
          stb_n_q <= 1'b0;
          blank_q <= HPM_BLANK_CYC;
          oe_q <= wr_q;
          bus_q <= half_lo;
          be_q <= be_lo;
        end
        HPM_STB1: if (dsp_ready) begin
          stb_n_q <= 1'b1;
          hsel_q <= 1'b1;
          rdata_q[15:0] <= rd_s2_q;
        end
        HPM_GAP: begin
          stb_n_q <= 1'b0;
          blank_q <= HPM_BLANK_CYC;
          bus_q <= half_hi;
          be_q <= be_hi;
        end
        HPM_STB2: if (dsp_ready) begin
          stb_n_q <= 1'b1;
          cs_n_q <= 1'b1;
          oe_q <= 1'b0;
          hsel_q <= 1'b0;
          be_q <= HPM_BE_RST;
          rdata_q[31:16] <= rd_s2_q;
        end
        HPM_DONE: begin
          // order flags set by control write and by address write
          if (sel_q == HPM_SEL_CTRL && wr_q) ctrl_done_q <= 1'b1;
          if (sel_q == HPM_SEL_ADDR && wr_q) addr_done_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Outputs straight from flops
  assign o_req_ready = ack_q;
  assign o_rsp_valid = rsp_q;
  assign o_rsp_rdata = rdata_q;
  assign o_seq_error = err_q;
  assign o_access_select_low = sel_q[0];
  assign o_access_select_high = sel_q[1];
  assign o_port_read_not_write = rnw_q;
  assign o_dsp0_chip_select_n = cs_n_q;
  assign o_port_data_strobe_n = stb_n_q;
  assign o_halfword_position_select = hsel_q;
  assign o_low_byte_enable_n = be_q[0];
  assign o_high_byte_enable_n = be_q[1];
  assign o_muxed_port_bus = bus_q;
  assign o_muxed_port_bus_oe = oe_q;

  property p_cs_during_stb;
    @(posedge i_clk) disable iff (i_rst)
    !stb_n_q |-> !cs_n_q;
  endproperty
  a_cs_during_stb: assert property (p_cs_during_stb)
    else $error("strobe without chip select");

  property p_hold_not_ready;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == HPM_STB1 && !dsp_ready) |=> !stb_n_q && !hsel_q;
  endproperty
  a_hold_not_ready: assert property (p_hold_not_ready)
    else $error("strobe released before ready");

  property p_hold_second;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == HPM_STB2 && !dsp_ready) |=> !stb_n_q && hsel_q;
  endproperty
  a_hold_second: assert property (p_hold_second)
    else $error("second strobe released before ready");

  property p_two_halves;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == HPM_STB1 && dsp_ready) |=> ##1 !stb_n_q && hsel_q;
  endproperty
  a_two_halves: assert property (p_two_halves)
    else $error("second half missing");

  property p_cs_end;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == HPM_STB2 && dsp_ready) |=> cs_n_q && stb_n_q;
  endproperty
  a_cs_end: assert property (p_cs_end)
    else $error("chip select not released");

  property p_seq_gate;
    @(posedge i_clk) disable iff (i_rst)
    (state_q == HPM_SETUP && sel_q[1]) |-> ctrl_done_q && addr_done_q;
  endproperty
  a_seq_gate: assert property (p_seq_gate)
    else $error("data access before setup");

  property p_low_first;
    @(posedge i_clk) disable iff (i_rst)
    $fell(stb_n_q) && !hsel_q && oe_q |-> bus_q == word_q[15:0];
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("low half not first");

  property p_sel_stable;
    @(posedge i_clk) disable iff (i_rst)
    !cs_n_q |=> $stable(sel_q) || cs_n_q;
  endproperty
  a_sel_stable: assert property (p_sel_stable)
    else $error("select changed in transfer");

  property p_be_read;
    @(posedge i_clk) disable iff (i_rst)
    (!stb_n_q && !wr_q) |-> be_q == 2'h0;
  endproperty
  a_be_read: assert property (p_be_read)
    else $error("byte enables not low on read");

  c_write: cover property (@(posedge i_clk) rsp_q && wr_q);
  c_read: cover property (@(posedge i_clk) rsp_q && !wr_q);
  c_wait: cover property (@(posedge i_clk)
    state_q == HPM_STB1 && !dsp_ready);
  c_err: cover property (@(posedge i_clk) err_q);
endmodule // hpm_master
`default_nettype wire

// [rtl/hpm_pkg.sv]
package hpm_pkg;
  // Access-select codes, high bit then low bit
  localparam logic [1:0] HPM_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPM_SEL_ADDR = 2'h1;
  localparam logic [1:0] HPM_SEL_DATA_INC = 2'h2;
  localparam logic [1:0] HPM_SEL_DATA_FIX = 2'h3;
  // Control word field positions, low half-word copy
  localparam int HPM_BIT_ORDER = 0;
  localparam int HPM_BIT_H2D_IRQ = 1;
  localparam int HPM_BIT_D2H_IRQ = 2;
  localparam int HPM_BIT_READY = 3;
  localparam int HPM_BIT_FETCH = 4;
  localparam int HPM_HALF_W = 16;
  // Reset values
  localparam logic [15:0] HPM_BUS_RST = 16'h0000;
  localparam logic [1:0] HPM_BE_RST = 2'h3;
  localparam logic [31:0] HPM_WORD_RST = 32'h0000_0000;
  // Ready samples ignored after each strobe falling edge, the pin's sync lag
  localparam logic [1:0] HPM_BLANK_CYC = 2'h3;
  // Bridge sequencing states, Gray coded along the strobe path
  typedef enum logic [2:0] {
    HPM_IDLE = 3'h0,
    HPM_SETUP = 3'h1,
    HPM_STB1 = 3'h3,
    HPM_GAP = 3'h2,
    HPM_STB2 = 3'h6,
    HPM_DONE = 3'h7
  } hpm_state_t;
endpackage

// [verification/hpm_dsp_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Far-side port slave with a small memory
module hpm_dsp_model import hpm_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_wait,
  input wire logic i_cs_n,
  input wire logic i_stb_n,
  input wire logic [1:0] i_sel,
  input wire logic i_rnw,
  input wire logic i_hsel,
  input wire logic [1:0] i_be_n,
  input wire logic [15:0] i_bus,
  output logic o_ready_n,
  output logic o_irq_n,
  output logic [15:0] o_bus,
  output logic o_early
);
  logic [31:0] mem [0:15];
  logic [31:0] ctl_q, adr_q, rdw, nw, m;
  logic [15:0] lo_q, bl_q;
  logic [3:0] cnt_q;
  logic [1:0] lb_q, bel_q, sel_q;
  logic act_q, hs_q, rnw_q, go, up;
  assign o_irq_n = ~ctl_q[HPM_BIT_D2H_IRQ];
  assign o_ready_n = !(act_q && cnt_q >= i_wait);
  assign go = !i_cs_n && !i_stb_n;
  assign up = act_q && i_stb_n;
  assign rdw = (i_sel == HPM_SEL_CTRL) ? (ctl_q | 32'h0008_0008) :
    (i_sel == HPM_SEL_ADDR) ? adr_q : mem[adr_q[3:0]];
  // first half is the low half
  assign nw = {bl_q, lo_q};
  assign m = {{8{~bel_q[1]}}, {8{~bel_q[0]}}, {8{~lb_q[1]}}, {8{~lb_q[0]}}};
  always_ff @(posedge i_clk) begin
    act_q <= go && !i_rst;
    cnt_q <= go ? cnt_q + 4'h1 : 4'h0;
    if (go) begin
      hs_q <= i_hsel;
      sel_q <= i_sel;
      rnw_q <= i_rnw;
      bl_q <= i_bus;
      bel_q <= i_be_n;
    end
    if (up && !hs_q) begin
      lo_q <= bl_q;
      lb_q <= bel_q;
    end
    if (up && hs_q) begin
      if (!rnw_q && sel_q == HPM_SEL_CTRL) ctl_q <= nw & 32'h0007_0007;
      if (!rnw_q && sel_q == HPM_SEL_ADDR) adr_q <= nw;
      if (!rnw_q && sel_q[1])
        mem[adr_q[3:0]] <= (nw & m) | (mem[adr_q[3:0]] & ~m);
      if (sel_q == HPM_SEL_DATA_INC) adr_q <= adr_q + 32'h1;
    end
    // Toggle when not read so stale data never looks valid
    o_bus <= i_rst ? 16'h5aa5 : (go && i_rnw) ?
      (i_hsel ? rdw[31:16] : rdw[15:0]) : ~o_bus;
    // flag a strobe ended before this side showed ready
    o_early <= !i_rst && up && (cnt_q < i_wait);
    if (i_rst) ctl_q <= 32'h0;
  end
endmodule // hpm_dsp_model
`default_nettype wire

// [verification/dsp_host_port_master_32bit_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module dsp_host_port_master_32bit_tb_top import hpm_pkg::*; ;
  logic i_clk, i_rst, vld, wr, rdy_n, oe, cs_n, stb_n, hs, sl, sh, rnw;
  logic b0, b1, qrdy, rspv, serr, e, irq_n, early;
  logic [1:0] sel;
  logic [3:0] be_n, wt;
  logic [31:0] wd, rdat, got;
  logic [15:0] dbus, mbus, pbus;
  int err_total, n_checks, cyc;
  // Resolved port bus level
  assign pbus = oe ? dbus : mbus;
  hpm_master DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(vld),
    .i_req_write(wr), .i_req_addr({2'h0, sel}), .i_req_wdata(wd),
    .i_req_be_n(be_n), .i_dsp0_ready_line_n(rdy_n), .i_muxed_port_bus(pbus),
    .o_req_ready(qrdy), .o_rsp_valid(rspv), .o_rsp_rdata(rdat),
    .o_seq_error(serr), .o_access_select_low(sl), .o_access_select_high(sh),
    .o_port_read_not_write(rnw), .o_dsp0_chip_select_n(cs_n),
    .o_port_data_strobe_n(stb_n), .o_halfword_position_select(hs),
    .o_low_byte_enable_n(b0), .o_high_byte_enable_n(b1),
    .o_muxed_port_bus(dbus), .o_muxed_port_bus_oe(oe));
  hpm_dsp_model M (.i_clk(i_clk), .i_rst(i_rst), .i_wait(wt), .i_cs_n(cs_n),
    .i_stb_n(stb_n), .i_sel({sh, sl}), .i_rnw(rnw), .i_hsel(hs),
    .i_be_n({b1, b0}), .i_bus(pbus), .o_ready_n(rdy_n), .o_irq_n(irq_n),
    .o_bus(mbus), .o_early(early));
  task automatic chk(input string nm, input logic [31:0] g,
                     input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One request held until taken, then its answer
  task automatic xf(input logic w, input logic [1:0] s, input logic [31:0] d,
                    input logic [3:0] b);
    int n;
    @(posedge i_clk);
    #2;
    vld = 1;
    wr = w;
    sel = s;
    wd = d;
    be_n = b;
    n = 0;
    while (qrdy !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    e = serr;
    #1;
    vld = 0;
    while (e !== 1'b1 && rspv !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    got = rdat;
    chk("answer_seen", n < 300, 1);
    chk("cs_release", cs_n, 1);
  endtask
  initial begin
    i_clk = 0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Hang guard, well above the longest run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end
  // Strobe released before the far side was ready
  always @(negedge i_clk) begin
    if (early !== 1'b0) chk("ready_wait", early, 0);
  end
  initial begin
    i_rst = 1;
    vld = 0;
    wr = 0;
    sel = 0;
    wd = 0;
    be_n = 4'hf;
    wt = 0;
    repeat (2) @(posedge i_clk);
    #2;
    i_rst = 0;
    xf(1, HPM_SEL_ADDR, 32'h4, 4'h0);
    chk("addr_first", e, 1);
    xf(1, HPM_SEL_CTRL, 32'hffff_ffff, 4'h0);
    chk("ctrl_taken", e, 0);
    chk("irq_pin", irq_n, 0);
    xf(0, HPM_SEL_CTRL, 0, 4'hf);
    chk("ctrl_read", got, 32'h000f_000f);
    xf(1, HPM_SEL_DATA_FIX, 32'h1, 4'h0);
    chk("data_early", e, 1);
    xf(1, HPM_SEL_ADDR, 32'h4, 4'h0);
    xf(0, HPM_SEL_ADDR, 0, 4'hf);
    chk("addr_read", got, 32'h4);
    wt = 4'h3;
    xf(1, HPM_SEL_DATA_FIX, 32'hddcc_bbaa, 4'h0);
    xf(0, HPM_SEL_DATA_FIX, 0, 4'hf);
    chk("fix_word", got, 32'hddcc_bbaa);
    xf(1, HPM_SEL_DATA_FIX, 32'h1122_3344, 4'h5);
    xf(0, HPM_SEL_DATA_FIX, 0, 4'hf);
    chk("byte_en", got, 32'h11cc_33aa);
    wt = 4'h7;
    for (int i = 0; i < 4; i++) begin
      xf(1, HPM_SEL_DATA_INC, 32'h5a00_0000 + i, 4'h0);
    end
    xf(1, HPM_SEL_ADDR, 32'h4, 4'h0);
    wt = 4'h0;
    for (int i = 0; i < 4; i++) begin
      xf(0, HPM_SEL_DATA_INC, 0, 4'hf);
      chk("inc_read", got, 32'h5a00_0000 + i);
    end
    // Mid-run reset forgets the setup, so data is refused again
    @(posedge i_clk);
    #2;
    i_rst = 1;
    repeat (2) @(posedge i_clk);
    #2;
    i_rst = 0;
    xf(0, HPM_SEL_DATA_INC, 0, 4'hf);
    chk("data_after_rst", e, 1);
    stop_test;
  end
endmodule // dsp_host_port_master_32bit_tb_top
`default_nettype wire
